// ### inc/prm_pkg.sv
// Constants and types shared by the pin, reset and mode control block
// =====================================================================
// How it works
// - Any reset drives the reset pin low for about 66 bus cycles.
// - Each reset sets the flag of its source in the cause status.
// - Reset pin is open drain; a low level from outside requests reset.
// - During power-on or debug-forced reset the debug pin is a mode input.
// - When any reset ends the debug pin becomes the debug line.
// - Debug pin high at release of a power-on or debug-forced reset selects normal run mode.
// - One debug bit lasts 16 debug clock cycles.
// - Debug clock may equal the full bus clock; timing stays correct.
// - The debug line driver emits short driven-high speedup pulses.
// - Up to 22 general-purpose pins, each shared with peripherals.
// - Output pins choose one of two drive strengths and slew limiting.
// - Input pins may enable an internal pull-up.
// - After reset each pin is a high-impedance input, pull-up off.
// - Peripheral owns the buffer enable; direction bit selects read data.
// - Ganged pins drive identically for more current when tied.
// - Alternates win in fixed order, fifth highest; port use lowest.
// - Ganged pins beat all digital modules and follow the master pin.
// - Comparator and converter both connect when both enabled.
package prm_pkg;

   // =================================================================
   // Sizes
   localparam int PRM_NUM_PINS    = 22;
   localparam int PRM_NUM_ALT     = 5;
   localparam int PRM_GANG_MASTER = 8;

   // =================================================================
   // Reset stretch, in bus cycles
   localparam int         PRM_RST_CYCLES = 66;
   localparam logic [6:0] PRM_RST_LAST   = 7'(PRM_RST_CYCLES - 1);

   // =================================================================
   // Debug bit time, in debug clock cycles
   localparam int         PRM_BIT_CYCLES = 16;
   localparam logic [3:0] PRM_BIT_LAST   = 4'(PRM_BIT_CYCLES - 1);

   // =================================================================
   // Reset cause status bit positions and values
   localparam int         PRM_CAUSE_POR  = 7;
   localparam int         PRM_CAUSE_PIN  = 6;
   localparam int         PRM_CAUSE_COP  = 5;
   localparam int         PRM_CAUSE_ILOP = 4;
   localparam int         PRM_CAUSE_DBGF = 2;
   localparam int         PRM_CAUSE_LVD  = 1;
   localparam logic [7:0] PRM_CAUSE_RST  = 8'h80;

   // =================================================================
   // Values after reset
   localparam logic PRM_MODE_RST  = 1'b0;
   localparam logic PRM_STRAP_RST = 1'b1;

   typedef enum logic [1:0] {
      RS_IDLE      = 2'b00,
      RS_STRETCH   = 2'b01,
      RS_WAIT_HIGH = 2'b10
   } prm_rst_state_type;

endpackage

// ### rtl/prm_pin_cell.sv
// Priority selection of one shared pin's output and enable
`timescale 1ns/1ps
module prm_pin_cell #(
   parameter int NUM_ALT = prm_pkg::PRM_NUM_ALT
) (
   input  wire logic               i_gang_en,
   input  wire logic               i_gang_data,
   input  wire logic [NUM_ALT-1:0] i_alt_en,
   input  wire logic [NUM_ALT-1:0] i_alt_out,
   input  wire logic [NUM_ALT-1:0] i_alt_oe,
   input  wire logic               i_port_data,
   input  wire logic               i_port_dir,
   output logic                    o_out,
   output logic                    o_oe
);
   import prm_pkg::*;

   always_comb begin
      o_out = i_port_data;
      o_oe  = i_port_dir;
      // Later alternates overwrite earlier ones
      for (int k = 0; k < NUM_ALT; k++) begin
         if (i_alt_en[k]) begin
            o_out = i_alt_out[k];
            o_oe  = i_alt_oe[k];
         end
      end
      // Ganged drive overrides every digital module
      if (i_gang_en) begin
         o_out = i_gang_data;
         o_oe  = 1'b1;
      end
   end

endmodule // prm_pin_cell

// ### rtl/prm_top.sv
// Reset stretch, boot mode strap, debug line and shared port pin control
`timescale 1ns/1ps
module prm_top #(
   parameter int NUM_PINS    = prm_pkg::PRM_NUM_PINS,
   parameter int NUM_ALT     = prm_pkg::PRM_NUM_ALT,
   parameter int GANG_MASTER = prm_pkg::PRM_GANG_MASTER
) (
   input  wire logic                               i_clk,
   input  wire logic                               i_rst,
   input  wire logic                               i_ce,
   // Reset pin and internal reset sources
   input  wire logic                               i_rst_pin_in,
   output logic                                    o_rst_pin_out,
   output logic                                    o_rst_pin_oe,
   input  wire logic                               i_por,
   input  wire logic                               i_lvd,
   input  wire logic                               i_cop,
   input  wire logic                               i_ill_op,
   input  wire logic                               i_dbg_force_rst,
   output logic                                    o_int_reset,
   output logic [7:0]                              o_reset_cause_status,
   output logic                                    o_boot_mode_strap,
   // Debug/mode select pin and debug controller side
   input  wire logic                               i_dbg_pin_in,
   output logic                                    o_dbg_pin_out,
   output logic                                    o_dbg_pin_oe,
   input  wire logic                               i_dbg_drive_low,
   input  wire logic                               i_dbg_bit_run,
   output logic                                    o_dbg_rx,
   output logic                                    o_dbg_bit_tick,
   // Port pins
   input  wire logic [NUM_PINS-1:0]                i_port_data,
   input  wire logic [NUM_PINS-1:0]                i_port_dir,
   input  wire logic [NUM_PINS-1:0]                i_hi_drive,
   input  wire logic [NUM_PINS-1:0]                i_slew_en,
   input  wire logic [NUM_PINS-1:0]                i_pullup_en,
   input  wire logic [NUM_PINS-1:0]                i_gang_en,
   input  wire logic [NUM_PINS-1:0][NUM_ALT-1:0]   i_alt_en,
   input  wire logic [NUM_PINS-1:0][NUM_ALT-1:0]   i_alt_out,
   input  wire logic [NUM_PINS-1:0][NUM_ALT-1:0]   i_alt_oe,
   input  wire logic [NUM_PINS-1:0]                i_acmp_en,
   input  wire logic [NUM_PINS-1:0]                i_adc_en,
   input  wire logic [NUM_PINS-1:0]                i_pin_in,
   output logic [NUM_PINS-1:0]                     o_pin_out,
   output logic [NUM_PINS-1:0]                     o_pin_oe,
   output logic [NUM_PINS-1:0]                     o_pin_hi_drive,
   output logic [NUM_PINS-1:0]                     o_pin_slew,
   output logic [NUM_PINS-1:0]                     o_pin_pullup,
   output logic [NUM_PINS-1:0]                     o_port_read,
   output logic [NUM_PINS-1:0]                     o_alt_in,
   output logic [NUM_PINS-1:0]                     o_acmp_conn,
   output logic [NUM_PINS-1:0]                     o_adc_conn
);
   import prm_pkg::*;

   // =================================================================
   // Input synchronisers
   logic                rst_s1_reg, rst_s2_reg;
   logic                dbg_s1_reg, dbg_s2_reg;
   logic [NUM_PINS-1:0] pin_s1_reg, pin_s2_reg;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= 1'b1;
         dbg_s1_reg <= 1'b1;
         dbg_s2_reg <= 1'b1;
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
      end else if (i_ce) begin
         rst_s1_reg <= i_rst_pin_in;
         rst_s2_reg <= rst_s1_reg;
         dbg_s1_reg <= i_dbg_pin_in;
         dbg_s2_reg <= dbg_s1_reg;
         pin_s1_reg <= i_pin_in;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   // =================================================================
   // Reset sequencer
   prm_rst_state_type state_reg, state_next;
   logic [6:0]        cnt_reg, cnt_next;
   logic [7:0]        cause_reg, cause_next;
   logic              strap_src_reg, strap_src_next;
   logic              boot_reg, boot_next;
   logic              rst_oe_reg, rst_oe_next;
   logic [7:0]        src;
   logic              int_req;
   logic              pin_low;

   assign pin_low = ~rst_s2_reg;
   assign int_req = i_por | i_lvd | i_cop | i_ill_op | i_dbg_force_rst;

   always_comb begin
      src                 = '0;
      src[PRM_CAUSE_POR]  = i_por;
      src[PRM_CAUSE_LVD]  = i_lvd;
      src[PRM_CAUSE_COP]  = i_cop;
      src[PRM_CAUSE_ILOP] = i_ill_op;
      src[PRM_CAUSE_DBGF] = i_dbg_force_rst;
      // Own drive reads back low, so the pin counts only when idle
      src[PRM_CAUSE_PIN]  = pin_low && (state_reg == RS_IDLE);
      state_next     = state_reg;
      cnt_next       = cnt_reg;
      cause_next     = cause_reg;
      strap_src_next = strap_src_reg;
      boot_next      = boot_reg;
      unique case (state_reg)
         RS_IDLE: begin
            if (|src) begin
               state_next     = RS_STRETCH;
               cnt_next       = '0;
               cause_next     = src;
               strap_src_next = i_por | i_dbg_force_rst;
            end
         end
         RS_STRETCH: begin
            if (int_req) begin
               cnt_next       = '0;
               cause_next     = cause_reg | src;
               strap_src_next = strap_src_reg | i_por | i_dbg_force_rst;
            end else if (cnt_reg == PRM_RST_LAST) begin
               state_next = RS_WAIT_HIGH;
            end else begin
               cnt_next = cnt_reg + 7'h01;
            end
         end
         RS_WAIT_HIGH: begin
            if (int_req) begin
               state_next     = RS_STRETCH;
               cnt_next       = '0;
               cause_next     = cause_reg | src;
               strap_src_next = strap_src_reg | i_por | i_dbg_force_rst;
            end else if (!pin_low) begin
               // Pin back high: internal reset ends here
               state_next = RS_IDLE;
               if (strap_src_reg) begin
                  boot_next      = ~dbg_s2_reg;
                  strap_src_next = 1'b0;
               end
            end
         end
         default: begin
            state_next = RS_IDLE;
         end
      endcase
      rst_oe_next = (state_next == RS_STRETCH);
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         // Power-up behaves as a power-on reset with a full stretch
         state_reg     <= RS_STRETCH;
         cnt_reg       <= '0;
         cause_reg     <= PRM_CAUSE_RST;
         strap_src_reg <= PRM_STRAP_RST;
         boot_reg      <= PRM_MODE_RST;
         rst_oe_reg    <= 1'b1;
      end else if (i_ce) begin
         state_reg     <= state_next;
         cnt_reg       <= cnt_next;
         cause_reg     <= cause_next;
         strap_src_reg <= strap_src_next;
         boot_reg      <= boot_next;
         rst_oe_reg    <= rst_oe_next;
      end
   end

   assign o_rst_pin_out        = 1'b0;
   assign o_rst_pin_oe         = rst_oe_reg;
   assign o_int_reset          = (state_reg != RS_IDLE);
   assign o_reset_cause_status = cause_reg;
   assign o_boot_mode_strap    = boot_reg;

   // =================================================================
   // Debug line: open drain with a one-cycle driven-high speedup
   logic       in_rst_next;
   logic       drv_d_reg, drv_d_next;
   logic       dbg_out_reg, dbg_out_next;
   logic       dbg_oe_reg, dbg_oe_next;
   logic       rx_reg, rx_next;
   logic [3:0] bit_cnt_reg, bit_cnt_next;
   logic       speed;

   always_comb begin
      // Debug role only outside reset; a mode input while in it
      in_rst_next  = (state_next != RS_IDLE);
      drv_d_next   = i_dbg_drive_low & ~in_rst_next;
      speed        = drv_d_reg & ~i_dbg_drive_low & ~in_rst_next;
      dbg_oe_next  = ~in_rst_next & (i_dbg_drive_low | speed);
      dbg_out_next = speed;
      rx_next      = in_rst_next | dbg_s2_reg;
      // Bit timer on the bus clock, so full-rate debug clock is fine
      if (!i_dbg_bit_run || o_int_reset || bit_cnt_reg == PRM_BIT_LAST) begin
         bit_cnt_next = '0;
      end else begin
         bit_cnt_next = bit_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         drv_d_reg   <= 1'b0;
         dbg_out_reg <= 1'b0;
         dbg_oe_reg  <= 1'b0;
         rx_reg      <= 1'b1;
         bit_cnt_reg <= '0;
      end else if (i_ce) begin
         drv_d_reg   <= drv_d_next;
         dbg_out_reg <= dbg_out_next;
         dbg_oe_reg  <= dbg_oe_next;
         rx_reg      <= rx_next;
         bit_cnt_reg <= bit_cnt_next;
      end
   end

   assign o_dbg_pin_out  = dbg_out_reg;
   assign o_dbg_pin_oe   = dbg_oe_reg;
   assign o_dbg_rx       = rx_reg;
   assign o_dbg_bit_tick = i_ce & i_dbg_bit_run & ~o_int_reset &
                           (bit_cnt_reg == PRM_BIT_LAST);

   // =================================================================
   // Shared port pins
   logic [NUM_PINS-1:0] cell_out, cell_oe;
   logic [NUM_PINS-1:0] out_reg, out_next, oe_reg, oe_next;
   logic [NUM_PINS-1:0] hi_reg, hi_next, slew_reg, slew_next;
   logic [NUM_PINS-1:0] pull_reg, pull_next, read_reg, read_next;
   logic [NUM_PINS-1:0] acmp_reg, acmp_next, adc_reg, adc_next;

   for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      prm_pin_cell #(
         .NUM_ALT     (NUM_ALT)
      ) u_cell (
         .i_gang_en   (i_gang_en[g]),
         .i_gang_data (i_port_data[GANG_MASTER]),
         .i_alt_en    (i_alt_en[g]),
         .i_alt_out   (i_alt_out[g]),
         .i_alt_oe    (i_alt_oe[g]),
         .i_port_data (i_port_data[g]),
         .i_port_dir  (i_port_dir[g]),
         .o_out       (cell_out[g]),
         .o_oe        (cell_oe[g])
      );
   end

   always_comb begin
      out_next  = cell_out;
      oe_next   = cell_oe;
      // Ganged pins take strength and slew from the master
      hi_next   = (i_gang_en & {NUM_PINS{i_hi_drive[GANG_MASTER]}}) |
                  (~i_gang_en & i_hi_drive);
      slew_next = (i_gang_en & {NUM_PINS{i_slew_en[GANG_MASTER]}}) |
                  (~i_gang_en & i_slew_en);
      pull_next = i_pullup_en & ~cell_oe;
      read_next = (i_port_dir & i_port_data) | (~i_port_dir & pin_s2_reg);
      acmp_next = i_acmp_en;
      adc_next  = i_adc_en;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         // Inputs, high impedance, pull-ups off
         out_reg  <= '0;
         oe_reg   <= '0;
         hi_reg   <= '0;
         slew_reg <= '0;
         pull_reg <= '0;
         read_reg <= '0;
         acmp_reg <= '0;
         adc_reg  <= '0;
      end else if (i_ce) begin
         out_reg  <= out_next;
         oe_reg   <= oe_next;
         hi_reg   <= hi_next;
         slew_reg <= slew_next;
         pull_reg <= pull_next;
         read_reg <= read_next;
         acmp_reg <= acmp_next;
         adc_reg  <= adc_next;
      end
   end

   assign o_pin_out      = out_reg;
   assign o_pin_oe       = oe_reg;
   assign o_pin_hi_drive = hi_reg;
   assign o_pin_slew     = slew_reg;
   assign o_pin_pullup   = pull_reg;
   assign o_port_read    = read_reg;
   assign o_alt_in       = pin_s2_reg;
   assign o_acmp_conn    = acmp_reg;
   assign o_adc_conn     = adc_reg;

   // =================================================================
   // Assertions
   sequence s_rst_start;
      i_ce && state_reg == RS_IDLE && pin_low;
   endsequence
   sequence s_rst_drive;
      o_rst_pin_oe && !o_rst_pin_out && cnt_reg == 7'h00;
   endsequence
   property p_pin_req;
      @(posedge i_clk) disable iff (i_rst) s_rst_start |=> s_rst_drive;
   endproperty
   a_pin_req: assert property (p_pin_req) else $error("pin low did not start stretch");

   property p_stretch_end;
      @(posedge i_clk) disable iff (i_rst)
         $fell(o_rst_pin_oe) |-> $past(cnt_reg) == PRM_RST_LAST;
   endproperty
   a_stretch_end: assert property (p_stretch_end) else $error("stretch length wrong");

   property p_restart;
      @(posedge i_clk) disable iff (i_rst)
         i_ce && state_reg != RS_IDLE && int_req |=> cnt_reg == 7'h00 && o_rst_pin_oe;
   endproperty
   a_restart: assert property (p_restart) else $error("request did not restart stretch");

   property p_cause;
      @(posedge i_clk) disable iff (i_rst)
         i_ce && state_reg == RS_IDLE && i_cop |=> o_reset_cause_status[PRM_CAUSE_COP];
   endproperty
   a_cause: assert property (p_cause) else $error("cause flag not set");

   property p_mode_input;
      @(posedge i_clk) disable iff (i_rst) o_int_reset |-> !o_dbg_pin_oe;
   endproperty
   a_mode_input: assert property (p_mode_input) else $error("debug pin driven in reset");

   logic strap_latch;
   assign strap_latch = i_ce && state_reg == RS_WAIT_HIGH && state_next == RS_IDLE && strap_src_reg;

   property p_strap_hold;
      @(posedge i_clk) disable iff (i_rst) !strap_latch |=> $stable(o_boot_mode_strap);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("mode strap changed");

   property p_run_mode;
      @(posedge i_clk) disable iff (i_rst)
         strap_latch && dbg_s2_reg |=> !o_boot_mode_strap && !o_int_reset;
   endproperty
   a_run_mode: assert property (p_run_mode) else $error("high pin did not give run mode");

   property p_speedup;
      @(posedge i_clk) disable iff (i_rst)
         i_ce && drv_d_reg && !i_dbg_drive_low && state_next == RS_IDLE |=> o_dbg_pin_oe && o_dbg_pin_out;
   endproperty
   a_speedup: assert property (p_speedup) else $error("no speedup pulse");

   property p_bit_tick;
      @(posedge i_clk) disable iff (i_rst) o_dbg_bit_tick |=> bit_cnt_reg == 4'h0;
   endproperty
   a_bit_tick: assert property (p_bit_tick) else $error("bit timer did not wrap");

   property p_gang;
      @(posedge i_clk) disable iff (i_rst) i_ce |=> ($past(i_gang_en) & ~o_pin_oe) == '0;
   endproperty
   a_gang: assert property (p_gang) else $error("ganged pin not driving");

   property p_pull;
      @(posedge i_clk) disable iff (i_rst) (o_pin_pullup & o_pin_oe) == '0;
   endproperty
   a_pull: assert property (p_pull) else $error("pull-up on an output");

   property p_read;
      @(posedge i_clk) disable iff (i_rst)
         i_ce |=> o_port_read == (($past(i_port_dir) & $past(i_port_data)) |
                                  (~$past(i_port_dir) & $past(pin_s2_reg)));
   endproperty
   a_read: assert property (p_read) else $error("port read source wrong");

endmodule // prm_top

// ### test/prm_board_model.sv
// Board model: pulled-up reset and debug lines, debug host and pad drivers
`timescale 1ns/1ps
module prm_board_model (
   input  wire logic                          i_rst_oe,
   input  wire logic                          i_rst_out,
   input  wire logic                          i_rst_hold,
   input  wire logic                          i_dbg_oe,
   input  wire logic                          i_dbg_out,
   input  wire logic                          i_dbg_hold,
   input  wire logic [prm_pkg::PRM_NUM_PINS-1:0] i_pad_oe,
   input  wire logic [prm_pkg::PRM_NUM_PINS-1:0] i_pad_out,
   input  wire logic [prm_pkg::PRM_NUM_PINS-1:0] i_board_val,
   output logic                               o_rst_line,
   output logic                               o_dbg_line,
   output logic [prm_pkg::PRM_NUM_PINS-1:0]      o_pad
);
   // ====================================
   // Wired levels
   // Open drain with pull-up; switch to ground wins
   assign o_rst_line = (i_rst_oe ? i_rst_out : 1'b1) & ~i_rst_hold;
   // Host holds the line low to ask for background mode
   assign o_dbg_line = i_dbg_oe ? i_dbg_out : ~i_dbg_hold;
   // Board holds every undriven pad at a level, so none floats
   assign o_pad      = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_board_val);
endmodule // prm_board_model

// ### test/prm_top_tb_top.sv
// Self-checking bench for the pin, reset and mode control block
`timescale 1ns/1ps
module prm_top_tb_top;
   import prm_pkg::*;
   localparam int N = PRM_NUM_PINS;
   typedef struct packed {
      logic       dir, data, pu, gang;
      logic [4:0] aen, aout, aoe;
      logic       an, pad, eout, eoe, epu, erd;
   } prm_tb_row_type;
   // Bits: dir data pu gang | alt en/out/oe | analog pad | out oe pullup read
   localparam logic [24:0] ROWS [8] = '{
      {4'h0, 5'h00, 5'h00, 5'h00, 2'h1, 4'h1}, {4'h2, 5'h00, 5'h00, 5'h00, 2'h2, 4'h2},
      {4'hE, 5'h00, 5'h00, 5'h00, 2'h0, 4'hD}, {4'h0, 5'h01, 5'h01, 5'h01, 2'h0, 4'hD},
      {4'h8, 5'h01, 5'h01, 5'h01, 2'h2, 4'hC}, {4'h0, 5'h11, 5'h01, 5'h11, 2'h0, 4'h4},
      {4'h2, 5'h06, 5'h02, 5'h02, 2'h1, 4'h3}, {4'h5, 5'h10, 5'h00, 5'h10, 2'h0, 4'hD}};
   localparam logic [7:0] CAUSES [6] = '{8'h02, 8'h20, 8'h10, 8'h04, 8'h80, 8'h40};
   logic i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_dbg_drive_low = 1'b0, i_dbg_bit_run = 1'b0;
   logic i_rst_pin_in, i_dbg_pin_in, i_por, i_lvd, i_cop, i_ill_op, i_dbg_force_rst;
   logic rst_hold = 1'b0, dbg_hold = 1'b1;
   logic [4:0] src = 5'h00;
   logic [N-1:0] i_port_data = '0, i_port_dir = '0, i_hi_drive = '0, i_slew_en = '0, i_pullup_en = '0;
   logic [N-1:0] i_gang_en = '0, i_acmp_en = '0, i_adc_en = '0, board = '0, i_pin_in;
   logic [N-1:0][4:0] i_alt_en = '0, i_alt_out = '0, i_alt_oe = '0;
   logic o_rst_pin_out, o_rst_pin_oe, o_int_reset, o_boot_mode_strap;
   logic o_dbg_pin_out, o_dbg_pin_oe, o_dbg_rx, o_dbg_bit_tick;
   logic [7:0] o_reset_cause_status;
   logic [N-1:0] o_pin_out, o_pin_oe, o_pin_hi_drive, o_pin_slew, o_pin_pullup;
   logic [N-1:0] o_port_read, o_alt_in, o_acmp_conn, o_adc_conn;
   int err_count = 0, num_checks = 0;
   assign {i_por, i_dbg_force_rst, i_ill_op, i_cop, i_lvd} = src;
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   prm_top dut_u (.i_clk, .i_rst, .i_ce, .i_rst_pin_in, .o_rst_pin_out, .o_rst_pin_oe, .i_por, .i_lvd, .i_cop,
      .i_ill_op, .i_dbg_force_rst, .o_int_reset, .o_reset_cause_status, .o_boot_mode_strap, .i_dbg_pin_in,
      .o_dbg_pin_out, .o_dbg_pin_oe, .i_dbg_drive_low, .i_dbg_bit_run, .o_dbg_rx, .o_dbg_bit_tick, .i_port_data,
      .i_port_dir, .i_hi_drive, .i_slew_en, .i_pullup_en, .i_gang_en, .i_alt_en, .i_alt_out, .i_alt_oe,
      .i_acmp_en, .i_adc_en, .i_pin_in, .o_pin_out, .o_pin_oe, .o_pin_hi_drive, .o_pin_slew, .o_pin_pullup,
      .o_port_read, .o_alt_in, .o_acmp_conn, .o_adc_conn);
   prm_board_model board_u (.i_rst_oe(o_rst_pin_oe), .i_rst_out(o_rst_pin_out), .i_rst_hold(rst_hold),
      .i_dbg_oe(o_dbg_pin_oe), .i_dbg_out(o_dbg_pin_out), .i_dbg_hold(dbg_hold), .i_pad_oe(o_pin_oe),
      .i_pad_out(o_pin_out), .i_board_val(board), .o_rst_line(i_rst_pin_in), .o_dbg_line(i_dbg_pin_in),
      .o_pad(i_pin_in));
   // ====================================
   // Shared tasks
   task automatic tally_and_finish();
      if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (o_int_reset !== 1'b0) begin
         @(negedge i_clk);
         n++;
         if (n > 400) begin
            err_count++;
            tally_and_finish();
         end
      end
   endtask
   // One-cycle request; returns on the edge the stretch is first seen
   task automatic pulse(input int k);
      @(negedge i_clk);
      src = 5'(1 << k);
      @(negedge i_clk);
      src = 5'h00;
   endtask
   task automatic count_low(output int n);
      n = 0;
      while (o_rst_pin_oe === 1'b1 && n < 300) begin
         n++;
         @(negedge i_clk);
      end
      if (n >= 300) begin
         err_count++;
         tally_and_finish();
      end
   endtask
   // ====================================
   // Main sequence
   initial begin
      int n;
      prm_tb_row_type r;
      repeat (4) @(negedge i_clk);
      chk("int_reset", o_int_reset, 1);
      chk("cause", o_reset_cause_status, 8'h80);
      chk("pin_oe", o_pin_oe, 0);
      chk("pin_pullup", o_pin_pullup, 0);
      i_rst = 1'b0;
      @(negedge i_clk);
      chk("dbg_oe", o_dbg_pin_oe, 0);
      chk("dbg_rx", o_dbg_rx, 1);
      wait_idle();
      chk("strap", o_boot_mode_strap, 1);
      repeat (3) @(negedge i_clk);
      chk("dbg_rx", o_dbg_rx, 0);
      for (int k = 0; k < 6; k++) begin
         dbg_hold = (k == 4);
         if (k < 5) begin
            pulse(k);
            count_low(n);
            chk("stretch", n, 66);
         end else begin
            rst_hold = 1'b1;
            repeat (5) @(negedge i_clk);
            rst_hold = 1'b0;
         end
         wait_idle();
         chk("cause", o_reset_cause_status, CAUSES[k]);
         chk("strap", o_boot_mode_strap, k != 3);
      end
      pulse(1);
      repeat (20) @(negedge i_clk);
      pulse(0);
      count_low(n);
      chk("restart", n, 66);
      wait_idle();
      chk("cause", o_reset_cause_status, 8'h22);
      i_dbg_drive_low = 1'b1;
      @(negedge i_clk);
      chk("dbg_low", {o_dbg_pin_oe, o_dbg_pin_out}, 2'h2);
      i_dbg_drive_low = 1'b0;
      @(negedge i_clk);
      chk("speedup", {o_dbg_pin_oe, o_dbg_pin_out}, 2'h3);
      @(negedge i_clk);
      chk("dbg_oe", o_dbg_pin_oe, 0);
      i_dbg_bit_run = 1'b1;
      for (int j = 0; j < 2; j++) begin
         n = 0;
         do begin
            @(negedge i_clk);
            n++;
         end while (o_dbg_bit_tick !== 1'b1 && n < 40);
         if (n >= 40) begin
            err_count++;
            tally_and_finish();
         end
         chk("bit_tick", n, (j == 0) ? 15 : 16);
      end
      i_dbg_bit_run = 1'b0;
      for (int i = 0; i < 8; i++) begin
         r = ROWS[i];
         i_port_dir = {N{r.dir}};
         i_port_data = {N{r.data}};
         i_pullup_en = {N{r.pu}};
         i_gang_en = {N{r.gang}};
         i_hi_drive = {N{~r.data}};
         i_slew_en = {N{r.data}};
         i_alt_en = {N{r.aen}};
         i_alt_out = {N{r.aout}};
         i_alt_oe = {N{r.aoe}};
         i_acmp_en = {N{r.an}};
         i_adc_en = {N{r.an}};
         board = {N{r.pad}};
         repeat (4) @(negedge i_clk);
         chk("pin_out", o_pin_out, {N{r.eout}});
         chk("pin_oe", o_pin_oe, {N{r.eoe}});
         chk("pin_pullup", o_pin_pullup, {N{r.epu}});
         chk("port_read", o_port_read, {N{r.erd}});
         chk("hi_drive", o_pin_hi_drive, i_hi_drive);
         chk("slew", o_pin_slew, i_slew_en);
         chk("alt_in", o_alt_in, i_pin_in);
         chk("analog", {o_acmp_conn, o_adc_conn}, {i_acmp_en, i_adc_en});
      end
      // Gang on one pin only, master data and drive differ from the rest
      i_gang_en = '0;
      i_gang_en[3] = 1'b1;
      i_port_data = '0;
      i_port_data[PRM_GANG_MASTER] = 1'b1;
      i_hi_drive = '0;
      i_hi_drive[PRM_GANG_MASTER] = 1'b1;
      repeat (2) @(negedge i_clk);
      chk("gang", {o_pin_out[3], o_pin_oe[3], o_pin_hi_drive[3]}, 3'h7);
      // Enable low: master data change must not reach the ganged pin
      i_ce = 1'b0;
      i_port_data = '0;
      repeat (3) @(negedge i_clk);
      chk("freeze", o_pin_out[3], 1);
      i_ce = 1'b1;
      repeat (2) @(negedge i_clk);
      chk("unfreeze", o_pin_out[3], 0);
      tally_and_finish();
   end
endmodule // prm_top_tb_top
